// file: rtl/sos_pkg.sv
// shared constants, types and helpers for the status output selector
package sos_pkg;

  localparam int FREQ_W = 16;
  localparam int VOLT_W = 12;
  localparam int SEL_W = 8;
  localparam int N_TERM = 4;
  localparam int N_CODES = 16;

  // base selection codes; each also indexes the status vector
  localparam int CODE_RUN = 0;
  localparam int CODE_ZERO_SPEED = 1;
  localparam int CODE_SPEED_AGREE = 2;
  localparam int CODE_USER_AGREE = 3;
  localparam int CODE_READY = 4;
  localparam int CODE_UNDERVOLT = 5;
  localparam int CODE_BASEBLOCK = 6;
  localparam int CODE_RESERVED = 7;
  localparam int CODE_FREQ_SRC = 8;
  localparam int CODE_CMD_LOSS = 9;
  localparam int CODE_RUN_SRC = 10;
  localparam int CODE_FAULT = 11;
  localparam int CODE_COMM = 12;
  localparam int CODE_ALARM = 13;
  localparam int CODE_FAULT_RESTART = 14;
  localparam int CODE_TIMER = 15;

  // hundreds digit one selects the inverted function
  localparam logic [SEL_W-1:0] SEL_INV_OFS = 8'h64;

  localparam logic [N_CODES-1:0] STAT_RESET = 16'h0000;
  localparam logic [N_TERM-1:0] TERM_RESET = 4'h0;
  localparam logic [1:0] LIVE_DONE = 2'h2;

  typedef enum logic [1:0] {
    SRC_KEYPAD,
    SRC_EXT_ONE,
    SRC_EXT_TWO
  } sos_src_t;

  function automatic logic [FREQ_W-1:0] mag_f(input logic signed [FREQ_W-1:0] v);
    mag_f = v[FREQ_W-1] ? FREQ_W'(-v) : FREQ_W'(v);
  endfunction

  // |a - b| <= w, one bit wider so the difference never wraps
  function automatic logic near_f(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b,
                                  input logic [FREQ_W-1:0] w);
    logic [FREQ_W:0] d;
    d = (a > b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, b} - {1'b0, a});
    near_f = d <= {1'b0, w};
  endfunction

endpackage

// file: rtl/sos_freq_cmp.sv
// frequency comparisons: zero speed, speed agree, user-defined agree
`timescale 1ns/1ps
`default_nettype none
module sos_freq_cmp
  import sos_pkg::*;
(
  // control method
  input wire logic closed_loop,
  // measured and commanded values, signed by direction
  input wire logic signed [FREQ_W-1:0] out_freq,
  input wire logic signed [FREQ_W-1:0] motor_speed,
  input wire logic signed [FREQ_W-1:0] freq_demand,
  input wire logic signed [FREQ_W-1:0] freq_cmd,
  // thresholds
  input wire logic [FREQ_W-1:0] min_output_freq_setting,
  input wire logic [FREQ_W-1:0] zero_hold_start_level,
  input wire logic [FREQ_W-1:0] freq_detect_level,
  input wire logic [FREQ_W-1:0] freq_detect_width,
  // results
  output logic zero_speed,
  output logic speed_agree,
  output logic user_agree
);

  logic [FREQ_W-1:0] fout_mag;
  logic [FREQ_W-1:0] actual_mag;
  logic [FREQ_W-1:0] zero_thr;

  always_comb begin
    fout_mag = mag_f(out_freq);
    // magnitudes make all three comparisons direction blind
    actual_mag = closed_loop ? mag_f(motor_speed) : fout_mag; // RL5
    zero_thr = closed_loop ? zero_hold_start_level : min_output_freq_setting; // RL3
    zero_speed = fout_mag < zero_thr; // RL2
    speed_agree = near_f(actual_mag, mag_f(freq_demand), freq_detect_width); // RL4
    user_agree = near_f(actual_mag, freq_detect_level, freq_detect_width) &&
                 near_f(mag_f(freq_cmd), freq_detect_level, freq_detect_width); // RL6
  end

endmodule
`default_nettype wire

// file: rtl/sos_term_sel.sv
// one output terminal: function selection, inversion, output flop
`timescale 1ns/1ps
`default_nettype none
module sos_term_sel
  import sos_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selection and registered status
  input wire logic [SEL_W-1:0] func_select,
  input wire logic [N_CODES-1:0] stat,
  // terminal
  output logic closed
);

  logic closed_reg;
  logic closed_next;
  logic inv;
  logic known;
  logic [SEL_W-1:0] base;

  always_comb begin
    inv = func_select >= SEL_INV_OFS; // RL19
    base = inv ? SEL_W'(func_select - SEL_INV_OFS) : func_select;
    // codes beyond the implemented set behave like reserved ones
    known = (base < SEL_W'(N_CODES)) && (base != SEL_W'(CODE_RESERVED));
    closed_next = known ? (stat[base[3:0]] ^ inv) : 1'b0; // RL21
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      closed_reg <= 1'b0;
    end else begin
      closed_reg <= closed_next;
    end
  end

  assign closed = closed_reg;

  reserved_open_a: assert property (@(posedge clk) disable iff (rst) // RL21
    (func_select == SEL_W'(CODE_RESERVED) || func_select == SEL_INV_OFS + SEL_W'(CODE_RESERVED)) |=> !closed)
    else $error("reserved code drove terminal closed");

  invert_a: assert property (@(posedge clk) disable iff (rst) // RL19
    (func_select == SEL_INV_OFS + SEL_W'(CODE_FAULT)) |=> (closed == !$past(stat[CODE_FAULT])))
    else $error("inverted code did not invert status");

endmodule
`default_nettype wire

// file: rtl/sos_status_output_selector.sv
// top: drive status collection and four multi-function output terminals
//
// What this block does
// RL1: code 0 closes while voltage is output: run command, DC braking, deceleration.
// RL2: code 1 closes while output frequency is below the zero-speed threshold.
// RL3: zero-speed threshold is zero-hold level in closed loop, else minimum frequency.
// RL4: code 2 closes when running output frequency is within width of demand.
// RL5: closed-loop speed agree compares measured motor speed instead of output frequency.
// RL6: code 3 closes when frequency and command both sit within level plus/minus width.
// RL7: code 4 closes when the drive is ready to run or running.
// RL8: code 5 closes while DC bus voltage is below the undervoltage level.
// RL9: code 6 closes while baseblock suppresses output switching.
// RL10: code 8 closes when the frequency command comes from the keypad.
// RL11: code 9 closes on command loss, gated by the loss detect selection.
// RL12: code 10 closes when the run command comes from the keypad.
// RL13: code 11 closes whenever a fault is active.
// RL14: code 12 follows the host-written bit; without a write it stays open.
// RL15: code 13 closes on feedback high, feedback low or overcurrent alarm.
// RL16: code 14 closes while a fault reset is being attempted.
// RL17: code 15 follows the timer function output.
// RL18: four terminals, each with its own function selection.
// RL19: codes 100 upward select code minus 100 with inverted terminal state.
// RL20: ready drops on fault, supply failure, parameter error, stop-time volt fault, programming.
// RL21: reserved codes such as 7 keep the terminal open.
`timescale 1ns/1ps
`default_nettype none
module sos_status_output_selector
  import sos_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // function selections
  input wire logic [SEL_W-1:0] relay_one_func_select,
  input wire logic [SEL_W-1:0] relay_two_func_select,
  input wire logic [SEL_W-1:0] opencoll_one_func_select,
  input wire logic [SEL_W-1:0] opencoll_two_func_select,
  // run state
  input wire logic drive_running,
  input wire logic run_cmd_active,
  input wire logic dc_braking,
  input wire logic decelerating,
  input wire logic baseblock_active,
  input wire logic closed_loop,
  // frequencies and thresholds
  input wire logic signed [FREQ_W-1:0] out_freq,
  input wire logic signed [FREQ_W-1:0] motor_speed,
  input wire logic signed [FREQ_W-1:0] freq_demand,
  input wire logic signed [FREQ_W-1:0] freq_cmd,
  input wire logic [FREQ_W-1:0] min_output_freq_setting,
  input wire logic [FREQ_W-1:0] zero_hold_start_level,
  input wire logic [FREQ_W-1:0] freq_detect_level,
  input wire logic [FREQ_W-1:0] freq_detect_width,
  // dc bus
  input wire logic [VOLT_W-1:0] dc_bus_voltage,
  input wire logic [VOLT_W-1:0] undervolt_detect_level,
  // command sources
  input wire sos_src_t freq_cmd_source,
  input wire sos_src_t run_cmd_source,
  input wire logic cmd_loss_detected,
  input wire logic cmd_loss_detect_select,
  // faults and alarms
  input wire logic fault_active,
  input wire logic supply_failure,
  input wire logic param_error,
  input wire logic volt_fault_stopped,
  input wire logic programming_mode,
  input wire logic feedback_high_alarm,
  input wire logic feedback_low_alarm,
  input wire logic overcurrent_alarm,
  input wire logic fault_reset_attempt,
  input wire logic timer_out,
  // host writes, one bit per terminal
  input wire logic [N_TERM-1:0] comm_wr_strobe,
  input wire logic [N_TERM-1:0] comm_wr_value,
  // terminals, high means closed
  output logic relay_one_closed,
  output logic relay_two_closed,
  output logic opencoll_one_closed,
  output logic opencoll_two_closed
);

  logic [N_CODES-1:0] stat_reg;
  logic [N_CODES-1:0] stat_next;
  logic [N_TERM-1:0] comm_reg;
  logic [N_TERM-1:0] comm_next;
  logic [N_TERM-1:0] term;
  logic [SEL_W-1:0] sel [N_TERM];
  logic zero_speed;
  logic speed_agree;
  logic user_agree;
  logic ready;
  // assertion helper: terminal flops reflect real inputs only after two edges
  logic [1:0] live_reg;
  logic [1:0] live_next;

  sos_freq_cmp u_cmp (
    .closed_loop(closed_loop),
    .out_freq(out_freq),
    .motor_speed(motor_speed),
    .freq_demand(freq_demand),
    .freq_cmd(freq_cmd),
    .min_output_freq_setting(min_output_freq_setting),
    .zero_hold_start_level(zero_hold_start_level),
    .freq_detect_level(freq_detect_level),
    .freq_detect_width(freq_detect_width),
    .zero_speed(zero_speed),
    .speed_agree(speed_agree),
    .user_agree(user_agree)
  );

  always_comb begin
    // blocked conditions win over running: a faulted drive never shows ready
    ready = !(fault_active || supply_failure || param_error ||
              volt_fault_stopped || programming_mode); // RL20
    stat_next = STAT_RESET;
    stat_next[CODE_RUN] = drive_running || run_cmd_active || dc_braking || decelerating; // RL1
    stat_next[CODE_ZERO_SPEED] = zero_speed; // RL2
    stat_next[CODE_SPEED_AGREE] = speed_agree && drive_running; // RL4
    stat_next[CODE_USER_AGREE] = user_agree; // RL6
    stat_next[CODE_READY] = ready; // RL7
    stat_next[CODE_UNDERVOLT] = dc_bus_voltage < undervolt_detect_level; // RL8
    stat_next[CODE_BASEBLOCK] = baseblock_active; // RL9
    stat_next[CODE_RESERVED] = 1'b0; // RL21
    stat_next[CODE_FREQ_SRC] = freq_cmd_source == SRC_KEYPAD; // RL10
    stat_next[CODE_CMD_LOSS] = cmd_loss_detected && cmd_loss_detect_select; // RL11
    stat_next[CODE_RUN_SRC] = run_cmd_source == SRC_KEYPAD; // RL12
    stat_next[CODE_FAULT] = fault_active; // RL13
    stat_next[CODE_ALARM] = feedback_high_alarm || feedback_low_alarm || overcurrent_alarm; // RL15
    stat_next[CODE_FAULT_RESTART] = fault_reset_attempt; // RL16
    stat_next[CODE_TIMER] = timer_out; // RL17
  end

  always_comb begin
    // each terminal keeps its last host value until overwritten
    comm_next = (comm_reg & ~comm_wr_strobe) | (comm_wr_value & comm_wr_strobe); // RL14
    live_next = (live_reg == LIVE_DONE) ? live_reg : live_reg + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= STAT_RESET;
      comm_reg <= TERM_RESET;
      live_reg <= 2'h0;
    end else begin
      stat_reg <= stat_next;
      comm_reg <= comm_next;
      live_reg <= live_next;
    end
  end

  always_comb begin
    sel[0] = relay_one_func_select;
    sel[1] = relay_two_func_select;
    sel[2] = opencoll_one_func_select;
    sel[3] = opencoll_two_func_select;
  end

  // the host bit is per terminal, so it replaces the shared code 12 slot
  for (genvar g = 0; g < N_TERM; g++) begin : g_term // RL18
    sos_term_sel u_sel (
      .clk(clk),
      .rst(rst),
      .func_select(sel[g]),
      .stat({stat_reg[N_CODES-1:CODE_COMM+1], comm_reg[g], stat_reg[CODE_COMM-1:0]}),
      .closed(term[g])
    );
  end

  assign relay_one_closed = term[0];
  assign relay_two_closed = term[1];
  assign opencoll_one_closed = term[2];
  assign opencoll_two_closed = term[3];

  // checks on all four terminals: input at edge n-2, selection at n-1, terminal at n
  run_close_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_RUN) &&
     $past(dc_braking, 2)) |-> relay_one_closed)
    else $error("run terminal open during dc braking");

  zero_thr_a: assert property (@(posedge clk) disable iff (rst) // RL3
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_ZERO_SPEED) && $past(closed_loop, 2) &&
     $past(mag_f(out_freq), 2) < $past(zero_hold_start_level, 2)) |-> relay_one_closed)
    else $error("zero speed ignored hold level in closed loop");

  agree_run_a: assert property (@(posedge clk) disable iff (rst) // RL4
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_SPEED_AGREE) &&
     !$past(drive_running, 2)) |-> !relay_one_closed)
    else $error("speed agree closed while stopped");

  ready_fault_a: assert property (@(posedge clk) disable iff (rst) // RL20
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_READY) &&
     $past(fault_active, 2)) |-> !relay_one_closed)
    else $error("ready shown during fault");

  uv_level_a: assert property (@(posedge clk) disable iff (rst) // RL8
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_UNDERVOLT)) |->
     relay_one_closed == ($past(dc_bus_voltage, 2) < $past(undervolt_detect_level, 2)))
    else $error("undervoltage terminal wrong");

  src_keypad_a: assert property (@(posedge clk) disable iff (rst) // RL10
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_FREQ_SRC)) |->
     relay_one_closed == ($past(freq_cmd_source, 2) == SRC_KEYPAD))
    else $error("frequency source terminal wrong");

  loss_gate_a: assert property (@(posedge clk) disable iff (rst) // RL11
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_CMD_LOSS) &&
     !$past(cmd_loss_detect_select, 2)) |-> !relay_one_closed)
    else $error("command loss shown while detection off");

  fault_close_a: assert property (@(posedge clk) disable iff (rst) // RL13
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_FAULT)) |->
     relay_two_closed == $past(fault_active, 2))
    else $error("fault terminal does not follow fault");

  comm_hold_a: assert property (@(posedge clk) disable iff (rst) // RL14
    (comm_wr_strobe[0] && comm_wr_value[0] ##1 !comm_wr_strobe[0] && sel[0] == SEL_W'(CODE_COMM))
     |=> relay_one_closed)
    else $error("host bit not held on terminal");

  alarm_close_a: assert property (@(posedge clk) disable iff (rst) // RL15
    (live_reg == LIVE_DONE && $past(sel[2]) == SEL_W'(CODE_ALARM) &&
     $past(overcurrent_alarm, 2)) |-> opencoll_one_closed)
    else $error("alarm terminal open on overcurrent");

  timer_follow_a: assert property (@(posedge clk) disable iff (rst) // RL17
    (live_reg == LIVE_DONE && $past(sel[3]) == SEL_W'(CODE_TIMER)) |->
     opencoll_two_closed == $past(timer_out, 2))
    else $error("timer terminal does not follow timer");

  restart_a: assert property (@(posedge clk) disable iff (rst) // RL16
    (live_reg == LIVE_DONE && $past(sel[3]) == SEL_W'(CODE_FAULT_RESTART)) |->
     opencoll_two_closed == $past(fault_reset_attempt, 2))
    else $error("fault restart terminal wrong");

  zero_min_a: assert property (@(posedge clk) disable iff (rst) // RL2
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_ZERO_SPEED) && !$past(closed_loop, 2)) |->
     relay_one_closed == ($past(mag_f(out_freq), 2) < $past(min_output_freq_setting, 2)))
    else $error("zero speed ignored minimum frequency");

  agree_band_a: assert property (@(posedge clk) disable iff (rst) // RL4
    (live_reg == LIVE_DONE && $past(sel[0]) == SEL_W'(CODE_SPEED_AGREE) && $past(drive_running, 2) &&
     !$past(closed_loop, 2)) |->
     relay_one_closed == $past(near_f(mag_f(out_freq), mag_f(freq_demand), freq_detect_width), 2))
    else $error("speed agree band wrong");

  agree_motor_a: assert property (@(posedge clk) disable iff (rst) // RL5
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_SPEED_AGREE) && $past(drive_running, 2) &&
     $past(closed_loop, 2)) |->
     relay_two_closed == $past(near_f(mag_f(motor_speed), mag_f(freq_demand), freq_detect_width), 2))
    else $error("closed loop speed agree ignored motor speed");

  user_band_a: assert property (@(posedge clk) disable iff (rst) // RL6
    (live_reg == LIVE_DONE && $past(sel[2]) == SEL_W'(CODE_USER_AGREE) &&
     !$past(near_f(mag_f(freq_cmd), freq_detect_level, freq_detect_width), 2)) |-> !opencoll_one_closed)
    else $error("user agree closed with command outside band");

  ready_run_a: assert property (@(posedge clk) disable iff (rst) // RL7
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_READY) &&
     !$past(fault_active || supply_failure || param_error || volt_fault_stopped || programming_mode, 2))
     |-> relay_two_closed)
    else $error("ready terminal open with nothing blocking");

  baseblock_show_a: assert property (@(posedge clk) disable iff (rst) // RL9
    (live_reg == LIVE_DONE && $past(sel[2]) == SEL_W'(CODE_BASEBLOCK)) |->
     opencoll_one_closed == $past(baseblock_active, 2))
    else $error("baseblock terminal wrong");

  run_src_a: assert property (@(posedge clk) disable iff (rst) // RL12
    (live_reg == LIVE_DONE && $past(sel[3]) == SEL_W'(CODE_RUN_SRC)) |->
     opencoll_two_closed == ($past(run_cmd_source, 2) == SRC_KEYPAD))
    else $error("run source terminal wrong");

  loss_show_a: assert property (@(posedge clk) disable iff (rst) // RL11
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_CMD_LOSS) &&
     $past(cmd_loss_detected && cmd_loss_detect_select, 2)) |-> relay_two_closed)
    else $error("command loss not shown");

  alarm_open_a: assert property (@(posedge clk) disable iff (rst) // RL15
    (live_reg == LIVE_DONE && $past(sel[3]) == SEL_W'(CODE_ALARM) &&
     !$past(feedback_high_alarm || feedback_low_alarm || overcurrent_alarm, 2)) |-> !opencoll_two_closed)
    else $error("alarm terminal closed without alarm");

  run_open_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_RUN) &&
     !$past(drive_running || run_cmd_active || dc_braking || decelerating, 2)) |-> !relay_two_closed)
    else $error("run terminal closed while stopped");

  term_indep_a: assert property (@(posedge clk) disable iff (rst) // RL18
    (live_reg == LIVE_DONE && $past(sel[2]) == SEL_W'(CODE_FAULT)) |->
     opencoll_one_closed == $past(fault_active, 2))
    else $error("third terminal does not follow its own selection");

  run_invert_a: assert property (@(posedge clk) disable iff (rst) // RL19
    (live_reg == LIVE_DONE && $past(sel[2]) == SEL_INV_OFS + SEL_W'(CODE_RUN)) |->
     opencoll_one_closed == !$past(drive_running || run_cmd_active || dc_braking || decelerating, 2))
    else $error("inverted run code did not invert");

  high_code_open_a: assert property (@(posedge clk) disable iff (rst) // RL21
    (live_reg == LIVE_DONE && $past(sel[3]) >= SEL_W'(N_CODES) && $past(sel[3]) < SEL_INV_OFS) |->
     !opencoll_two_closed)
    else $error("unimplemented code drove terminal closed");

  comm_follow_a: assert property (@(posedge clk) disable iff (rst) // RL14
    (live_reg == LIVE_DONE && $past(sel[1]) == SEL_W'(CODE_COMM)) |->
     relay_two_closed == $past(comm_reg[1]))
    else $error("host bit not shown on second terminal");

endmodule
`default_nettype wire

// file: tb/sos_host_load_model.sv
// supervising controller writes and terminal loads seen from outside
`timescale 1ns/1ps
`default_nettype none
module sos_host_load_model
  import sos_pkg::*;
(
  // clock
  input wire logic clk,
  // terminals, high means closed
  input wire logic [N_TERM-1:0] term_closed,
  // host write port
  output logic [N_TERM-1:0] comm_wr_strobe,
  output logic [N_TERM-1:0] comm_wr_value,
  // load state, one relay pick-up cycle behind
  output logic [N_TERM-1:0] load_on
);
  initial begin
    comm_wr_strobe = 4'h0;
    comm_wr_value = 4'h0;
    load_on = 4'h0;
  end

  always @(posedge clk) begin
    load_on <= term_closed;
  end

  // value line shows the inverse once released, so a stale value never looks valid
  task automatic host_write(input logic [N_TERM-1:0] mask, input logic [N_TERM-1:0] val);
    @(posedge clk);
    comm_wr_strobe <= mask;
    comm_wr_value <= val;
    @(posedge clk);
    comm_wr_strobe <= 4'h0;
    comm_wr_value <= ~val;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_status_output_selector.sv
// self-checking bench for the status output selector
`timescale 1ns/1ps
`default_nettype none
module tb_status_output_selector
  import sos_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [SEL_W-1:0] sel0 = 8'h00, sel1 = 8'h00, sel2 = 8'h00, sel3 = 8'h00;
  logic [3:0] run_v = 4'h0;
  logic [4:0] blk_v = 5'h00;
  logic [2:0] alm_v = 3'h0;
  logic [1:0] misc_v = 2'h0;
  logic [1:0] loss_v = 2'h0;
  logic bb = 1'b0, cl = 1'b0;
  logic signed [FREQ_W-1:0] ofq = 16'h0000, msp = 16'h0000, dem = 16'h0000, cmd = 16'h0000;
  logic [FREQ_W-1:0] minf = 16'h0000, zhl = 16'h0000, flv = 16'h0000, fwd = 16'h0000;
  logic [VOLT_W-1:0] vbus = 12'h000, uvl = 12'h000;
  sos_src_t fsrc = SRC_KEYPAD, rsrc = SRC_KEYPAD;
  wire logic [N_TERM-1:0] stb, val, load_on, terms;
  int failures = 0, tests_run = 0, cyc = 0;

  always #12.5 clk = ~clk;

  sos_status_output_selector uut (
    .clk(clk), .rst(rst),
    .relay_one_func_select(sel0), .relay_two_func_select(sel1),
    .opencoll_one_func_select(sel2), .opencoll_two_func_select(sel3),
    .drive_running(run_v[0]), .run_cmd_active(run_v[1]), .dc_braking(run_v[2]), .decelerating(run_v[3]),
    .baseblock_active(bb), .closed_loop(cl),
    .out_freq(ofq), .motor_speed(msp), .freq_demand(dem), .freq_cmd(cmd),
    .min_output_freq_setting(minf), .zero_hold_start_level(zhl),
    .freq_detect_level(flv), .freq_detect_width(fwd),
    .dc_bus_voltage(vbus), .undervolt_detect_level(uvl),
    .freq_cmd_source(fsrc), .run_cmd_source(rsrc),
    .cmd_loss_detected(loss_v[0]), .cmd_loss_detect_select(loss_v[1]),
    .fault_active(blk_v[0]), .supply_failure(blk_v[1]), .param_error(blk_v[2]),
    .volt_fault_stopped(blk_v[3]), .programming_mode(blk_v[4]),
    .feedback_high_alarm(alm_v[0]), .feedback_low_alarm(alm_v[1]), .overcurrent_alarm(alm_v[2]),
    .fault_reset_attempt(misc_v[0]), .timer_out(misc_v[1]),
    .comm_wr_strobe(stb), .comm_wr_value(val),
    .relay_one_closed(terms[0]), .relay_two_closed(terms[1]),
    .opencoll_one_closed(terms[2]), .opencoll_two_closed(terms[3])
  );

  sos_host_load_model ctl (
    .clk(clk), .term_closed(terms), .comm_wr_strobe(stb), .comm_wr_value(val), .load_on(load_on)
  );

  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // bounded run: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_sel(input int a, input int b, input int c, input int d);
    @(posedge clk);
    sel0 <= SEL_W'(a);
    sel1 <= SEL_W'(b);
    sel2 <= SEL_W'(c);
    sel3 <= SEL_W'(d);
  endtask

  // status to terminal takes two edges; wait three to be clear of it
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // plain code on all four terminals, then the inverted code
  task automatic go(input int code, input logic exp);
    logic inv;
    inv = (code == CODE_RESERVED || code >= N_CODES) ? 1'b0 : ~exp;
    set_sel(code, code, code, code);
    settle();
    chk(terms, {4{exp}});
    set_sel(code + 100, code + 100, code + 100, code + 100);
    settle();
    chk(terms, {4{inv}});
  endtask

  initial begin
    int i;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk) run_v <= 4'h1 << i;
      go(CODE_RUN, 1'b1);
    end
    @(posedge clk) run_v <= 4'h0;
    go(CODE_RUN, 1'b0);
    @(posedge clk) begin minf <= 16'h0064; zhl <= 16'h0032; ofq <= 16'h0063; end
    go(CODE_ZERO_SPEED, 1'b1);
    @(posedge clk) ofq <= 16'h0064;
    go(CODE_ZERO_SPEED, 1'b0);
    @(posedge clk) ofq <= 16'hff9d;
    go(CODE_ZERO_SPEED, 1'b1);
    @(posedge clk) begin cl <= 1'b1; ofq <= 16'h0032; end
    go(CODE_ZERO_SPEED, 1'b0);
    @(posedge clk) ofq <= 16'h0031;
    go(CODE_ZERO_SPEED, 1'b1);
    @(posedge clk) begin cl <= 1'b0; run_v <= 4'h1; dem <= 16'h03e8; fwd <= 16'h000a; ofq <= 16'h03f2; end
    go(CODE_SPEED_AGREE, 1'b1);
    @(posedge clk) ofq <= 16'h03f3;
    go(CODE_SPEED_AGREE, 1'b0);
    @(posedge clk) begin ofq <= 16'hfc13; dem <= 16'hfc18; end
    go(CODE_SPEED_AGREE, 1'b1);
    @(posedge clk) run_v <= 4'h0;
    go(CODE_SPEED_AGREE, 1'b0);
    @(posedge clk) begin cl <= 1'b1; run_v <= 4'h1; ofq <= 16'hfc18; msp <= 16'hfc04; end
    go(CODE_SPEED_AGREE, 1'b0);
    @(posedge clk) msp <= 16'hfc12;
    go(CODE_SPEED_AGREE, 1'b1);
    @(posedge clk) begin cl <= 1'b0; flv <= 16'h01f4; fwd <= 16'h0014; ofq <= 16'h0208; cmd <= 16'hfe20; end
    go(CODE_USER_AGREE, 1'b1);
    @(posedge clk) cmd <= 16'h01df;
    go(CODE_USER_AGREE, 1'b0);
    @(posedge clk) begin cl <= 1'b1; ofq <= 16'h0000; msp <= 16'h01f4; cmd <= 16'h01f4; end
    go(CODE_USER_AGREE, 1'b1);
    @(posedge clk) run_v <= 4'h0;
    go(CODE_READY, 1'b1);
    for (i = 0; i < 5; i++) begin
      @(posedge clk) begin blk_v <= 5'h01 << i; run_v <= 4'h1; end
      go(CODE_READY, 1'b0);
    end
    @(posedge clk) begin blk_v <= 5'h00; run_v <= 4'h0; vbus <= 12'h063; uvl <= 12'h064; end
    go(CODE_UNDERVOLT, 1'b1);
    @(posedge clk) vbus <= 12'h064;
    go(CODE_UNDERVOLT, 1'b0);
    @(posedge clk) bb <= 1'b1;
    go(CODE_BASEBLOCK, 1'b1);
    @(posedge clk) bb <= 1'b0;
    go(CODE_BASEBLOCK, 1'b0);
    go(CODE_RESERVED, 1'b0);
    go(16, 1'b0);
    go(50, 1'b0);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) begin fsrc <= sos_src_t'(i); rsrc <= sos_src_t'(2 - i); end
      go(CODE_FREQ_SRC, i == 0);
      go(CODE_RUN_SRC, i == 2);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk) loss_v <= 2'(i);
      go(CODE_CMD_LOSS, i == 3);
    end
    @(posedge clk) begin loss_v <= 2'h0; blk_v <= 5'h01; end
    go(CODE_FAULT, 1'b1);
    @(posedge clk) blk_v <= 5'h02;
    go(CODE_FAULT, 1'b0);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) alm_v <= 3'h1 << i;
      go(CODE_ALARM, 1'b1);
    end
    @(posedge clk) alm_v <= 3'h0;
    go(CODE_ALARM, 1'b0);
    for (i = 0; i < 2; i++) begin
      @(posedge clk) misc_v <= 2'h1 << i;
      go(CODE_FAULT_RESTART, i == 0);
      go(CODE_TIMER, i == 1);
    end
    @(posedge clk) begin misc_v <= 2'h0; blk_v <= 5'h00; end
    go(CODE_COMM, 1'b0);
    set_sel(CODE_COMM, CODE_COMM, CODE_COMM, CODE_COMM);
    ctl.host_write(4'h1, 4'h1);
    settle();
    chk(terms, 4'h1);
    ctl.host_write(4'h6, 4'h6);
    ctl.host_write(4'h1, 4'h0);
    settle();
    chk(terms, 4'h6);
    set_sel(112, 112, 112, 112);
    settle();
    chk(terms, 4'h9);
    @(posedge clk) blk_v <= 5'h01;
    set_sel(CODE_FAULT, CODE_RUN, CODE_READY + 100, CODE_BASEBLOCK);
    settle();
    chk(terms, 4'h5);
    chk(load_on, 4'h5);
    summarize();
  end
endmodule
`default_nettype wire
